//--- src/remr_pkg.sv
/*
 * constants, carrier types and helpers shared by the rail enable override register block.
 * assumes: one 25 MHz clock domain, registers reached over a two-wire serial target.
 */
package remr_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] REMR_AUX_DIS_OFS = 8'h9F; // auxiliary rail disable register
    localparam logic [7:0] REMR_FORCE1_OFS = 8'hA0; // first force-on register
    localparam logic [7:0] REMR_AUX_DIS_RST = 8'hF0; // four disable bits set, reserved clear
    localparam logic [7:0] REMR_FORCE1_RST = 8'h00; // default force-on pattern
    localparam logic [7:0] REMR_UNMAPPED_RD = 8'h00; // read answer for unmapped offsets

    // ==========================================================
    // field positions, auxiliary disable register
    localparam int REMR_SHARED_DIS_BIT = 7;
    localparam int REMR_SWITCH_B_ONE_DIS_BIT = 6;
    localparam int REMR_SWITCH_A_ONE_DIS_BIT = 5;
    localparam int REMR_TERM_DIS_BIT = 4;

    // ==========================================================
    // field positions, first force-on register (also index into rail_main)
    localparam int REMR_REG_A_TWO_BIT = 7;
    localparam int REMR_SWITCH_A_ONE_BIT = 6;
    localparam int REMR_STEPDOWN_LSB = 0; // stepdown one..six at bits 0..5

    // ==========================================================
    // serial target constants
    localparam logic [6:0] REMR_DEV_ADDR = 7'h5E; // arbitrary target address
    localparam logic [3:0] REMR_BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] REMR_PH_ADDR = 2'h0;
    localparam logic [1:0] REMR_PH_PTR = 2'h1;
    localparam logic [1:0] REMR_PH_DATA = 2'h2;

    // ==========================================================
    // types
    typedef enum logic [4:0] {
        REMR_ST_IDLE = 5'h01,
        REMR_ST_RX = 5'h02,
        REMR_ST_ACK = 5'h04,
        REMR_ST_TX = 5'h08,
        REMR_ST_RACK = 5'h10
    } remr_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } remr_bus_evt_t;

    typedef struct packed {
        logic [7:0] rail_main; // same bit order as the force-on register
        logic shared_rail;
        logic switch_b_one;
        logic term;
    } remr_rail_t;

    // ==========================================================
    // rail gating: disable wins, else force-on or pin request
    function automatic logic remr_rail_on(input logic dis_n, input logic force_on, input logic req);
        remr_rail_on = dis_n & (force_on | req);
    endfunction : remr_rail_on

endpackage : remr_pkg

//--- src/remr_line_sampler.sv
/*
 * samples the two serial bus lines and flags start, stop and clock edges.
 * assumes: scl and sda inputs are synchronous to sys_clk.
 */
`timescale 1ns/100ps
module remr_line_sampler (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    // decoded events
    output remr_pkg::remr_bus_evt_t evt
);
    import remr_pkg::*;

    logic scl_q;
    logic sda_q;
    logic scl_p_q;
    logic sda_p_q;

    // ==========================================================
    // current and previous line levels, idle high at reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            scl_p_q <= scl_q;
            sda_p_q <= sda_q;
        end
    end

    // ==========================================================
    // data moving while clock high marks start or stop
    assign evt = '{
        start: scl_q & scl_p_q & sda_p_q & ~sda_q,
        stop: scl_q & scl_p_q & ~sda_p_q & sda_q,
        scl_rise: scl_q & ~scl_p_q,
        scl_fall: ~scl_q & scl_p_q,
        sda: sda_q
    };

endmodule : remr_line_sampler

//--- src/remr_rail_gate.sv
/*
 * combines disable bits, force-on bits and pin requests into registered rail enables.
 * assumes: all inputs come from sys_clk flops or synchronous pins.
 */
`timescale 1ns/100ps
module remr_rail_gate (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire logic [7:0] dis_main_n,
    input wire logic [7:0] force_on,
    input wire logic [7:0] aux_dis_n,
    input wire logic shared_is_switch,
    input remr_pkg::remr_rail_t req,
    // enables
    output remr_pkg::remr_rail_t rail_en_q,
    output logic switch_b_two_en_q,
    output logic reg_a_one_en_q
);
    import remr_pkg::*;

    logic shared_on;

    assign shared_on = remr_rail_on(aux_dis_n[REMR_SHARED_DIS_BIT], 1'b0, req.shared_rail);

    // ==========================================================
    // all rail enables in one process, so the struct has a single writer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rail_en_q <= '0;
            switch_b_two_en_q <= 1'b0;
            reg_a_one_en_q <= 1'b0;
        end else begin
            for (int k = 0; k < 8; k++) begin
                rail_en_q.rail_main[k] <= remr_rail_on(dis_main_n[k], force_on[k], req.rail_main[k]);
            end
            rail_en_q.shared_rail <= shared_on;
            rail_en_q.switch_b_one <= remr_rail_on(aux_dis_n[REMR_SWITCH_B_ONE_DIS_BIT], 1'b0, req.switch_b_one);
            rail_en_q.term <= remr_rail_on(aux_dis_n[REMR_TERM_DIS_BIT], 1'b0, req.term);
            switch_b_two_en_q <= shared_on & shared_is_switch;
            reg_a_one_en_q <= shared_on & ~shared_is_switch;
        end
    end

endmodule : remr_rail_gate

//--- src/remr_top.sv
/*
 * rail enable override register block: serial target, two override registers, rail gating.
 * assumes: bus lines and requests synchronous to sys_clk; host keeps reserved bits zero.
 */
// Operation
// - aux bit 7 low forces shared rail off
// - factory strap picks switch or regulator rail
// - aux bit 6 low holds switch b one off
// - aux bit 5 low holds switch a one off
// - aux bit 4 low holds termination regulator off
// - force bit clear leaves pins in control
// - force bit 7 turns regulator a two on
// - force bit 6 turns switch a one on
// - force bit 5 turns stepdown six on
// - force bit 4 turns stepdown five on
// - force bit 3 turns stepdown four on
// - force bit 2 turns stepdown three on
// - force bit 1 turns stepdown two on
// - force bit 0 turns stepdown one on
// - external disables force stepdown rails and regulator a two off
`timescale 1ns/100ps
module remr_top #(
    parameter logic [6:0] DEV_ADDR = remr_pkg::REMR_DEV_ADDR,
    parameter logic [7:0] FORCE1_RST = remr_pkg::REMR_FORCE1_RST
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // serial register bus, open drain data
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // factory selection, high selects switch b two
    input wire logic shared_sel_switch,
    // enable requests from control pins and power good
    input remr_pkg::remr_rail_t rail_req,
    // disables held elsewhere, low forces off: bit 6 regulator a two, 5..0 stepdown six..one
    input wire logic [6:0] ext_disable_n,
    // rail enables and register state
    output remr_pkg::remr_rail_t rail_en,
    output logic switch_b_two_en,
    output logic reg_a_one_en,
    output logic [7:0] aux_disable,
    output logic [7:0] force_on
);
    import remr_pkg::*;

    remr_bus_evt_t evt;
    remr_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shreg_q;
    logic [1:0] phase_q;
    logic rw_q;
    logic [7:0] ptr_q;
    logic sda_oe_n_q;
    logic wr_stb_q;
    logic [7:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic [7:0] aux_dis_q;
    logic [7:0] force1_q;
    logic strap_taken_q;
    logic shared_sel_q;
    logic sda_out_q;
    logic [7:0] dis_main_n;

    // ==========================================================
    // register read mux, unmapped offsets answer zero
    function automatic logic [7:0] read_reg(input logic [7:0] addr, input logic [7:0] aux, input logic [7:0] frc);
        unique case (addr)
            REMR_AUX_DIS_OFS: read_reg = aux;
            REMR_FORCE1_OFS: read_reg = frc;
            default: read_reg = REMR_UNMAPPED_RD;
        endcase
    endfunction : read_reg

    // ==========================================================
    // bus line sampling
    remr_line_sampler u_sampler (
        .sys_clk(sys_clk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .evt(evt)
    );

    // ==========================================================
    // serial target: address, pointer, data bytes with pointer auto-increment
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= REMR_ST_IDLE;
            bit_cnt_q <= 4'h0;
            shreg_q <= 8'h00;
            phase_q <= REMR_PH_ADDR;
            rw_q <= 1'b0;
            ptr_q <= 8'h00;
            sda_oe_n_q <= 1'b1;
            wr_stb_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_stb_q <= 1'b0;
            if (evt.stop) begin
                state_q <= REMR_ST_IDLE;
                sda_oe_n_q <= 1'b1;
            end else if (evt.start) begin
                state_q <= REMR_ST_RX;
                bit_cnt_q <= 4'h0;
                phase_q <= REMR_PH_ADDR;
                sda_oe_n_q <= 1'b1;
            end else begin
                unique case (state_q)
                    REMR_ST_IDLE: begin
                        sda_oe_n_q <= 1'b1;
                    end
                    REMR_ST_RX: begin
                        if (evt.scl_rise && bit_cnt_q != REMR_BITS_PER_BYTE) begin
                            shreg_q <= {shreg_q[6:0], evt.sda};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (evt.scl_fall && bit_cnt_q == REMR_BITS_PER_BYTE) begin
                            unique case (phase_q)
                                REMR_PH_ADDR: begin
                                    if (shreg_q[7:1] == DEV_ADDR) begin
                                        rw_q <= shreg_q[0];
                                        phase_q <= REMR_PH_PTR;
                                        sda_oe_n_q <= 1'b0; // acknowledge
                                        state_q <= REMR_ST_ACK;
                                    end else begin
                                        state_q <= REMR_ST_IDLE; // not ours, stay silent
                                    end
                                end
                                REMR_PH_PTR: begin
                                    ptr_q <= shreg_q;
                                    phase_q <= REMR_PH_DATA;
                                    sda_oe_n_q <= 1'b0;
                                    state_q <= REMR_ST_ACK;
                                end
                                default: begin
                                    wr_stb_q <= 1'b1;
                                    wr_addr_q <= ptr_q;
                                    wr_data_q <= shreg_q;
                                    ptr_q <= ptr_q + 8'h01;
                                    sda_oe_n_q <= 1'b0;
                                    state_q <= REMR_ST_ACK;
                                end
                            endcase
                        end
                    end
                    REMR_ST_ACK: begin
                        if (evt.scl_fall) begin
                            if (rw_q) begin
                                shreg_q <= read_reg(ptr_q, aux_dis_q, force1_q);
                                sda_oe_n_q <= read_reg(ptr_q, aux_dis_q, force1_q) >> 7 != 8'h00;
                                ptr_q <= ptr_q + 8'h01;
                                bit_cnt_q <= 4'h1;
                                state_q <= REMR_ST_TX;
                            end else begin
                                sda_oe_n_q <= 1'b1;
                                bit_cnt_q <= 4'h0;
                                state_q <= REMR_ST_RX;
                            end
                        end
                    end
                    REMR_ST_TX: begin
                        if (evt.scl_fall) begin
                            if (bit_cnt_q == REMR_BITS_PER_BYTE) begin
                                sda_oe_n_q <= 1'b1; // release for host acknowledge
                                state_q <= REMR_ST_RACK;
                            end else begin
                                shreg_q <= {shreg_q[6:0], 1'b0};
                                sda_oe_n_q <= shreg_q[6];
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                            end
                        end
                    end
                    REMR_ST_RACK: begin
                        if (evt.scl_rise && evt.sda) begin
                            state_q <= REMR_ST_IDLE; // host ended the read
                        end else if (evt.scl_fall) begin
                            shreg_q <= read_reg(ptr_q, aux_dis_q, force1_q);
                            sda_oe_n_q <= read_reg(ptr_q, aux_dis_q, force1_q) >> 7 != 8'h00;
                            ptr_q <= ptr_q + 8'h01;
                            bit_cnt_q <= 4'h1;
                            state_q <= REMR_ST_TX;
                        end
                    end
                    default: begin
                        state_q <= REMR_ST_IDLE;
                        sda_oe_n_q <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // auxiliary disable register, reserved bits stored as written
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aux_dis_q <= REMR_AUX_DIS_RST;
        end else if (wr_stb_q && wr_addr_q == REMR_AUX_DIS_OFS) begin
            aux_dis_q <= wr_data_q;
        end
    end

    // ==========================================================
    // first force-on register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            force1_q <= FORCE1_RST;
        end else if (wr_stb_q && wr_addr_q == REMR_FORCE1_OFS) begin
            force1_q <= wr_data_q;
        end
    end

    // ==========================================================
    // factory selection caught once after reset release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            strap_taken_q <= 1'b0;
            shared_sel_q <= 1'b0;
        end else if (!strap_taken_q) begin
            strap_taken_q <= 1'b1;
            shared_sel_q <= shared_sel_switch;
        end
    end

    // ==========================================================
    // open drain data never drives high; outputs of register state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sda_out_q <= 1'b0;
        end else begin
            sda_out_q <= 1'b0;
        end
    end
    assign sda_out = sda_out_q;
    assign sda_oe_n = sda_oe_n_q;
    assign aux_disable = aux_dis_q;
    assign force_on = force1_q;

    // ==========================================================
    // disable vector in force-on bit order
    assign dis_main_n = {ext_disable_n[6], aux_dis_q[REMR_SWITCH_A_ONE_DIS_BIT], ext_disable_n[5:0]};

    remr_rail_gate u_gate (
        .sys_clk(sys_clk),
        .rst(rst),
        .dis_main_n(dis_main_n),
        .force_on(force1_q),
        .aux_dis_n(aux_dis_q),
        .shared_is_switch(shared_sel_q),
        .req(rail_req),
        .rail_en_q(rail_en),
        .switch_b_two_en_q(switch_b_two_en),
        .reg_a_one_en_q(reg_a_one_en)
    );

    // ==========================================================
    // checks
    property p_shared_off;
        @(posedge sys_clk) disable iff (rst)
        !aux_dis_q[REMR_SHARED_DIS_BIT] |=> !switch_b_two_en && !reg_a_one_en && !rail_en.shared_rail;
    endproperty
    a_shared_off: assert property (p_shared_off) else $error("shared rail on while disabled");

    property p_shared_select;
        @(posedge sys_clk) disable iff (rst)
        strap_taken_q && aux_dis_q[REMR_SHARED_DIS_BIT] && rail_req.shared_rail
            |=> switch_b_two_en == shared_sel_q && reg_a_one_en == !shared_sel_q;
    endproperty
    a_shared_select: assert property (p_shared_select) else $error("shared rail selection wrong");

    property p_switch_b_one_off;
        @(posedge sys_clk) disable iff (rst)
        !aux_dis_q[REMR_SWITCH_B_ONE_DIS_BIT] |=> !rail_en.switch_b_one;
    endproperty
    a_switch_b_one_off: assert property (p_switch_b_one_off) else $error("switch b one on while disabled");

    property p_switch_a_one_off;
        @(posedge sys_clk) disable iff (rst)
        !aux_dis_q[REMR_SWITCH_A_ONE_DIS_BIT] |=> !rail_en.rail_main[REMR_SWITCH_A_ONE_BIT];
    endproperty
    a_switch_a_one_off: assert property (p_switch_a_one_off) else $error("switch a one on while disabled");

    property p_term_off;
        @(posedge sys_clk) disable iff (rst)
        !aux_dis_q[REMR_TERM_DIS_BIT] |=> !rail_en.term;
    endproperty
    a_term_off: assert property (p_term_off) else $error("termination regulator on while disabled");

    property p_pin_control;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |=> (rail_en.rail_main & ~$past(force1_q)) == ($past(dis_main_n & rail_req.rail_main) & ~$past(force1_q));
    endproperty
    a_pin_control: assert property (p_pin_control) else $error("unforced rail not following pins");

    property p_force_wins;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |=> (rail_en.rail_main & $past(force1_q & dis_main_n)) == $past(force1_q & dis_main_n);
    endproperty
    a_force_wins: assert property (p_force_wins) else $error("forced rail not on");

    property p_ext_off;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |=> (rail_en.rail_main & ~$past(dis_main_n)) == 8'h00;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("rail on while externally disabled");

    property p_equation;
        @(posedge sys_clk) disable iff (rst)
        1'b1 |=> rail_en.rail_main == $past(dis_main_n & (force1_q | rail_req.rail_main));
    endproperty
    a_equation: assert property (p_equation) else $error("rail enable equation broken");

    property p_reset_defaults;
        @(posedge sys_clk)
        $fell(rst) |-> aux_dis_q == REMR_AUX_DIS_RST && force1_q == FORCE1_RST;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("register default wrong");

    sequence s_write_aux;
        wr_stb_q && wr_addr_q == REMR_AUX_DIS_OFS;
    endsequence
    sequence s_aux_takes_data;
        ##1 aux_dis_q == $past(wr_data_q)
        ##1 rail_en.term == ($past(wr_data_q[REMR_TERM_DIS_BIT], 2) & $past(rail_req.term));
    endsequence
    property p_aux_write;
        @(posedge sys_clk) disable iff (rst)
        s_write_aux |-> s_aux_takes_data;
    endproperty
    a_aux_write: assert property (p_aux_write) else $error("disable register write lost");

endmodule : remr_top

//--- tb/remr_host.sv
/* bus host model for the override registers: start, stop, bytes, reads.
   assumes: data line resolved with a pull-up in the bench. */
`timescale 1ns/100ps
module remr_host (
    // clock
    input wire logic sys_clk,
    // bus lines
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    import remr_pkg::*;
    // bus idles released
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // ==========
    // bit level
    task automatic tk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tk
    // data moves while scl is low, sampled just before scl falls
    task automatic bt(input logic b, output logic r);
        sda_drv <= b;
        tk(3);
        scl <= 1'b1;
        tk(4);
        r = sda_line;
        scl <= 1'b0;
        tk(2);
    endtask : bt
    // start or repeated start
    task automatic st();
        sda_drv <= 1'b1;
        tk(2);
        scl <= 1'b1;
        tk(4);
        sda_drv <= 1'b0;
        tk(4);
        scl <= 1'b0;
        tk(2);
    endtask : st
    task automatic sp();
        sda_drv <= 1'b0;
        tk(2);
        scl <= 1'b1;
        tk(4);
        sda_drv <= 1'b1;
        tk(4);
    endtask : sp
    // byte msb first, then the acknowledge slot
    task automatic by(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bt(d[i], q[i]);
        end
        bt(ak, a);
    endtask : by
    // ==========
    // transfers of two data bytes from a pointer
    task automatic wr(input logic [6:0] a7, input logic [7:0] p, input logic [15:0] d, output logic ok);
        logic [7:0] q;
        logic [3:0] a;
        st();
        by({a7, 1'b0}, 1'b1, q, a[0]);
        by(p, 1'b1, q, a[1]);
        by(d[15:8], 1'b1, q, a[2]);
        by(d[7:0], 1'b1, q, a[3]);
        sp();
        ok = (a == 4'h0);
    endtask : wr
    task automatic rd(input logic [7:0] p, output logic [15:0] d, output logic ok);
        logic [7:0] q;
        logic [3:0] a;
        st();
        by({REMR_DEV_ADDR, 1'b0}, 1'b1, q, a[0]);
        by(p, 1'b1, q, a[1]);
        st();
        by({REMR_DEV_ADDR, 1'b1}, 1'b1, q, a[2]);
        by(8'hFF, 1'b0, d[15:8], a[3]);
        by(8'hFF, 1'b1, d[7:0], a[3]);
        sp();
        ok = (a[2:0] == 3'h0);
    endtask : rd
endmodule : remr_host

//--- tb/tb_remr_top.sv
/* self-checking bench: integer model of both registers and the rail gating.
   assumes: host model remr_host and default design parameters. */
`timescale 1ns/100ps
module tb_remr_top;
    import remr_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic sel = 1'b1;
    logic scl, sda_drv, sda_out, sda_oe_n, sb2_en, ra1_en, ok;
    wire sda_line = sda_drv & (sda_oe_n | sda_out);
    remr_rail_t req = '0;
    remr_rail_t rail_en;
    logic [6:0] ext_n = 7'h7F;
    logic [7:0] aux_q, frc_q;
    logic [15:0] rv;
    int num_errors = 0;
    int tests_run = 0;
    int m_aux, m_frc;
    // clock
    always #20 sys_clk = ~sys_clk;
    remr_top u_remr_top (.sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .shared_sel_switch(sel), .rail_req(req), .ext_disable_n(ext_n), .rail_en(rail_en),
        .switch_b_two_en(sb2_en), .reg_a_one_en(ra1_en), .aux_disable(aux_q), .force_on(frc_q));
    remr_host u_remr_host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
    // ==========
    // comparisons
    task automatic tally(input string nm, input logic [12:0] e, input logic [12:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : tally
    task automatic cmp_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
        tally(nm, {5'h0, e}, {5'h0, g});
    endtask : cmp_reg
    // model: disable and (force or request), shared rail routed by strap
    task automatic chk_rails();
        logic [7:0] dm;
        logic sh;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        dm = {ext_n[6], m_aux[5], ext_n[5:0]};
        sh = m_aux[7] & req.shared_rail;
        tally("rails", {dm & (m_frc[7:0] | req.rail_main), sh, m_aux[6] & req.switch_b_one,
            m_aux[4] & req.term, sh & sel, sh & ~sel}, {rail_en, sb2_en, ra1_en});
    endtask : chk_rails
    // write both registers from the lower offset, read back over the bus and at the ports
    task automatic wreg(input logic [15:0] d);
        u_remr_host.wr(REMR_DEV_ADDR, REMR_AUX_DIS_OFS, d, ok);
        cmp_reg("write ack", 8'h01, {7'h0, ok});
        m_aux = d[15:8];
        m_frc = d[7:0];
        u_remr_host.rd(REMR_AUX_DIS_OFS, rv, ok);
        cmp_reg("read ack", 8'h01, {7'h0, ok});
        cmp_reg("aux read", m_aux[7:0], rv[15:8]);
        cmp_reg("force read", m_frc[7:0], rv[7:0]);
        cmp_reg("aux port", m_aux[7:0], aux_q);
        cmp_reg("force port", m_frc[7:0], frc_q);
        chk_rails();
    endtask : wreg
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    // ==========
    // tests
    initial begin
        void'($urandom(32'h98F3F201));
        fork
            begin
                repeat (60000) @(posedge sys_clk); // about two and a quarter times the expected run
                num_errors++;
                finish_test();
            end
        join_none
        for (int s = 1; s >= 0; s--) begin
            @(posedge sys_clk);
            rst <= 1'b1;
            sel <= s[0];
            req <= '0;
            ext_n <= 7'h7F;
            repeat (5) @(posedge sys_clk);
            rst <= 1'b0;
            m_aux = 'hF0;
            m_frc = 0;
            @(negedge sys_clk);
            cmp_reg("aux reset", 8'hF0, aux_q);
            cmp_reg("force reset", 8'h00, frc_q);
            for (int i = 0; i < 8; i++) begin
                wreg({8'hF0, 8'h01 << i});
            end
            @(posedge sys_clk);
            req <= 11'h7FF;
            ext_n <= 7'h00;
            wreg(16'h00FF);
            wreg(16'hF000);
            for (int k = 0; k < 6; k++) begin
                @(posedge sys_clk);
                req <= 11'($urandom);
                ext_n <= 7'($urandom);
                wreg({8'($urandom) & 8'hF0, 8'($urandom)});
            end
            $display("test strap %0d done", s);
        end
        // foreign address ignored, unmapped offsets acked and read as zero
        u_remr_host.wr(REMR_DEV_ADDR ^ 7'h01, REMR_AUX_DIS_OFS, 16'h0000, ok);
        cmp_reg("foreign ack", 8'h00, {7'h0, ok});
        u_remr_host.wr(REMR_DEV_ADDR, 8'h10, 16'hA5A5, ok);
        cmp_reg("unmapped ack", 8'h01, {7'h0, ok});
        u_remr_host.rd(8'h10, rv, ok);
        cmp_reg("unmapped read", 8'h00, rv[15:8]);
        cmp_reg("aux kept", m_aux[7:0], aux_q);
        cmp_reg("force kept", m_frc[7:0], frc_q);
        $display("test bus refusals done");
        finish_test();
    end
endmodule : tb_remr_top
